// ### core/spf_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH
// Byte addresses of the register words
`define SPF_CTRL_ADDR 12'h000
`define SPF_RATIO_ADDR 12'h004
`define SPF_GAIN_ADDR 12'h008
`define SPF_DEV_ADDR 12'h00C
`define SPF_STATUS_ADDR 12'h010
`define SPF_RATE_ADDR 12'h014
// Control word fields
`define SPF_CTRL_OUTSEL_LSB 0
`define SPF_CTRL_FMT_LSB 4
`define SPF_CTRL_SYNC_IDX_LSB 8
`define SPF_CTRL_SYNC_FN_LSB 16
// Ratio word fields
`define SPF_RATIO_NUM_LSB 0
`define SPF_RATIO_DEN_LSB 16
// Gain word fields, each an 8.8 fixed point factor
`define SPF_GAIN_KP_LSB 0
`define SPF_GAIN_FF_LSB 16
// Reset values
`define SPF_OUTSEL_RST 4'h0
`define SPF_FMT_RST 2'h0
`define SPF_SYNC_IDX_RST 4'h0
`define SPF_SYNC_FN_RST 5'h00
`define SPF_RATIO_RST 14'h0001
`define SPF_KP_RST 16'h0100
`define SPF_FF_RST 16'h0100
// Special codes
`define SPF_OUTSEL_REPEAT 4'h9
`define SPF_FN_SYNC 5'd27
`define SPF_RATIO_MAX 14'd9999
`define SPF_FMT_MAX 2'h2
// Speed rate window
`define SPF_CLK_MHZ 25
`define SPF_RATE_WIN_US 100
`define SPF_RATE_WIN_CYC (`SPF_RATE_WIN_US * `SPF_CLK_MHZ)
`endif

// ### core/spf_pkg.sv
// Types shared by the follower files
package spf_pkg;
  // Command pulse input formats
  typedef enum logic [1:0] {
    FMT_QUAD = 2'b00,
    FMT_SIGN = 2'b01,
    FMT_FWDREV = 2'b10
  } spf_fmt_t;
  // Follower operating states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCUM = 2'b01,
    ST_RUN = 2'b10,
    ST_LOCK = 2'b11
  } spf_state_t;
endpackage

// ### core/spf_decoder.sv
// Command pulse train decoder for the three input formats
`timescale 1ns/1ns
module spf_decoder (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  input wire logic [1:0] fmt_in,
  input wire logic invert_in,
  output logic step_out,
  output logic fwd_out
);
  logic a_q, b_q, a_d, b_d;
  logic step_raw, fwd_raw;

  ////////////////////////////////////////////////////////////////////
  // Previous phase levels
  always_comb begin
    a_d = phase_a_in;
    b_d = phase_b_in;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Edge decode per format
  always_comb begin
    step_raw = 1'b0;
    fwd_raw = 1'b1;
    case (fmt_in)
      spf_pkg::FMT_QUAD: begin
        // Every edge of both phases counts; a double change is dropped
        step_raw = (phase_a_in ^ a_q) ^ (phase_b_in ^ b_q);
        fwd_raw = ~(phase_a_in ^ b_q);
      end
      spf_pkg::FMT_SIGN: begin
        step_raw = phase_a_in & ~a_q;
        fwd_raw = phase_b_in;
      end
      spf_pkg::FMT_FWDREV: begin
        // Coincident edges on both lines cancel
        step_raw = (phase_a_in & ~a_q) ^ (phase_b_in & ~b_q);
        fwd_raw = phase_a_in & ~a_q;
      end
      default: begin
        step_raw = 1'b0;
        fwd_raw = 1'b1;
      end
    endcase
    step_out = step_raw;
    fwd_out = fwd_raw ^ invert_in;
  end

  // A lone rising edge on the reverse line must count as reverse before invert
  a_invert_swap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fmt_in == spf_pkg::FMT_FWDREV && phase_b_in && !b_q && !(phase_a_in && !a_q)
    |-> step_out && (fwd_out == invert_in))
    else $error("reverse line pulse not decoded as reverse");
endmodule

// ### core/spf_follower.sv
// Synchronized pulse follower with APB registers
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "spf_regs.svh"
module spf_follower #(
  parameter int MAX_SPEED = 32767,
  parameter int RATE_WIN = `SPF_RATE_WIN_CYC
) (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic CMD_IN_FIRST_PHASE_IN,
  input wire logic CMD_IN_SECOND_PHASE_IN,
  input wire logic DIRECTION_INVERT_IN,
  input wire logic FORWARD_RUN_IN,
  input wire logic [13:0] GENERAL_DIGITAL_INPUTS_IN,
  input wire logic FB_STEP_IN,
  input wire logic FB_FWD_IN,
  output logic REPEAT_OUT_FIRST_PHASE_OUT,
  output logic REPEAT_OUT_FIRST_PHASE_OE_OUT,
  output logic REPEAT_OUT_SECOND_PHASE_OUT,
  output logic REPEAT_OUT_SECOND_PHASE_OE_OUT,
  output logic signed [15:0] SPEED_CMD_OUT,
  output logic MOTOR_RUN_OUT,
  output logic SERVO_LOCK_OUT
);
  localparam logic [11:0] WIN_LAST = 12'(RATE_WIN - 1);

  logic [3:0] outsel_q, outsel_d;
  logic [1:0] fmt_q, fmt_d;
  logic [3:0] sidx_q, sidx_d;
  logic [4:0] sfn_q, sfn_d;
  logic [13:0] num_q, num_d, den_q, den_d;
  logic [15:0] kp_q, kp_d, ff_q, ff_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d, err_q, err_d;
  logic setup, wr_acc;
  logic dec_step, dec_fwd, sync_on;
  logic signed [23:0] res_q, res_d, wgt, dsum;
  logic cmd_up, cmd_dn;
  logic signed [31:0] dev_q, dev_d;
  logic [11:0] win_q, win_d;
  logic signed [15:0] cnt_q, cnt_d, rate_q, rate_d;
  spf_pkg::spf_state_t st_q, st_d;
  logic signed [15:0] spd_q, spd_d;
  logic signed [47:0] p_term, f_term, sum_term;
  logic rpa_q, rpa_d, rpb_q, rpb_d, rpen_d;
  logic run_q, run_d, lock_q, lock_d;

  // Clamp a ratio field into its legal range
  function automatic logic [13:0] clamp_ratio(input logic [13:0] v);
    if (v == 14'h0000) begin
      clamp_ratio = 14'h0001;
    end else if (v > `SPF_RATIO_MAX) begin
      clamp_ratio = `SPF_RATIO_MAX;
    end else begin
      clamp_ratio = v;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, data latched at setup
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN & ready_q;
  always_comb begin
    outsel_d = outsel_q;
    fmt_d = fmt_q;
    sidx_d = sidx_q;
    sfn_d = sfn_q;
    num_d = num_q;
    den_d = den_q;
    kp_d = kp_q;
    ff_d = ff_q;
    rdata_d = 32'h0000_0000;
    ready_d = setup;
    err_d = 1'b0;
    // Decode during setup so read data and error stand in the access phase
    if (setup) begin
      if (PADDR_IN == `SPF_CTRL_ADDR) begin
        rdata_d = {11'h000, sfn_q, 4'h0, sidx_q, 2'h0, fmt_q, outsel_q};
      end else if (PADDR_IN == `SPF_RATIO_ADDR) begin
        rdata_d = {2'h0, den_q, 2'h0, num_q};
      end else if (PADDR_IN == `SPF_GAIN_ADDR) begin
        rdata_d = {ff_q, kp_q};
      end else if (PADDR_IN == `SPF_DEV_ADDR) begin
        rdata_d = dev_q;
      end else if (PADDR_IN == `SPF_STATUS_ADDR) begin
        rdata_d = {28'h000_0000, st_q, sync_on, SERVO_LOCK_OUT};
      end else if (PADDR_IN == `SPF_RATE_ADDR) begin
        rdata_d = {{16{rate_q[15]}}, rate_q};
      end else begin
        err_d = 1'b1;
      end
    end
    // Writes take effect at the access edge
    if (wr_acc && !err_q) begin
      if (PADDR_IN == `SPF_CTRL_ADDR) begin
        outsel_d = PWDATA_IN[`SPF_CTRL_OUTSEL_LSB +: 4];
        // Formats above 2 are not accepted; the old one is kept
        if (PWDATA_IN[`SPF_CTRL_FMT_LSB +: 2] <= `SPF_FMT_MAX) begin
          fmt_d = PWDATA_IN[`SPF_CTRL_FMT_LSB +: 2];
        end
        sidx_d = PWDATA_IN[`SPF_CTRL_SYNC_IDX_LSB +: 4];
        sfn_d = PWDATA_IN[`SPF_CTRL_SYNC_FN_LSB +: 5];
      end else if (PADDR_IN == `SPF_RATIO_ADDR) begin
        num_d = clamp_ratio(PWDATA_IN[`SPF_RATIO_NUM_LSB +: 14]);
        den_d = clamp_ratio(PWDATA_IN[`SPF_RATIO_DEN_LSB +: 14]);
      end else if (PADDR_IN == `SPF_GAIN_ADDR) begin
        kp_d = PWDATA_IN[`SPF_GAIN_KP_LSB +: 16];
        ff_d = PWDATA_IN[`SPF_GAIN_FF_LSB +: 16];
      end
    end
  end
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      outsel_q <= `SPF_OUTSEL_RST;
      fmt_q <= `SPF_FMT_RST;
      sidx_q <= `SPF_SYNC_IDX_RST;
      sfn_q <= `SPF_SYNC_FN_RST;
      num_q <= `SPF_RATIO_RST;
      den_q <= `SPF_RATIO_RST;
      kp_q <= `SPF_KP_RST;
      ff_q <= `SPF_FF_RST;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      outsel_q <= outsel_d;
      fmt_q <= fmt_d;
      sidx_q <= sidx_d;
      sfn_q <= sfn_d;
      num_q <= num_d;
      den_q <= den_d;
      kp_q <= kp_d;
      ff_q <= ff_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end
  assign PRDATA_OUT = rdata_q;
  assign PREADY_OUT = ready_q;
  assign PSLVERR_OUT = err_q;

  ////////////////////////////////////////////////////////////////////
  // Pulse decode and sync enable selection
  spf_decoder u_dec (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .phase_a_in(CMD_IN_FIRST_PHASE_IN),
    .phase_b_in(CMD_IN_SECOND_PHASE_IN),
    .fmt_in(fmt_q),
    .invert_in(DIRECTION_INVERT_IN),
    .step_out(dec_step),
    .fwd_out(dec_fwd)
  );
  // Reverse run is not an input here: direction comes from the decoded pulses, flipped by invert
  assign sync_on = (sfn_q == `SPF_FN_SYNC) && (sidx_q < 4'd14)
    && GENERAL_DIGITAL_INPUTS_IN[sidx_q];

  ////////////////////////////////////////////////////////////////////
  // Ratio scaler: residue in units of 1/(4*den) command counts
  assign dsum = 24'(den_q) <<< 2;
  always_comb begin
    // Quadrature edges weigh alpha 4, other pulses alpha 1
    wgt = (fmt_q == spf_pkg::FMT_QUAD) ? (24'(num_q) <<< 2) : 24'(num_q);
    cmd_up = res_q >= dsum;
    cmd_dn = res_q <= -dsum;
    res_d = res_q;
    // One command count drains per cycle, so large ratios smear over cycles
    if (cmd_up) begin
      res_d = res_d - dsum;
    end else if (cmd_dn) begin
      res_d = res_d + dsum;
    end
    if (dec_step && sync_on) begin
      res_d = dec_fwd ? res_d + wgt : res_d - wgt;
    end
    if (!sync_on) begin
      res_d = 24'sh00_0000;
    end
  end
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      res_q <= 24'sh00_0000;
    end else begin
      res_q <= res_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Deviation counter and command rate over a fixed window
  always_comb begin
    dev_d = dev_q;
    if (cmd_up && sync_on) begin
      dev_d = dev_d + 32'sd1;
    end else if (cmd_dn && sync_on) begin
      dev_d = dev_d - 32'sd1;
    end
    if (FB_STEP_IN && sync_on) begin
      dev_d = FB_FWD_IN ? dev_d - 32'sd1 : dev_d + 32'sd1;
    end
    // Outside sync the loop is released and the deviation discarded
    if (!sync_on) begin
      dev_d = 32'sh0000_0000;
    end
    win_d = (win_q == WIN_LAST) ? 12'h000 : win_q + 12'h001;
    cnt_d = cnt_q;
    rate_d = rate_q;
    if (win_q == WIN_LAST) begin
      rate_d = cnt_q;
      cnt_d = 16'sh0000;
    end
    if (cmd_up && sync_on) begin
      cnt_d = cnt_d + 16'sd1;
    end else if (cmd_dn && sync_on) begin
      cnt_d = cnt_d - 16'sd1;
    end
  end
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dev_q <= 32'sh0000_0000;
      win_q <= 12'h000;
      cnt_q <= 16'sh0000;
      rate_q <= 16'sh0000;
    end else begin
      dev_q <= dev_d;
      win_q <= win_d;
      cnt_q <= cnt_d;
      rate_q <= rate_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operating state
  always_comb begin
    st_d = st_q;
    case (st_q)
      spf_pkg::ST_IDLE: begin
        if (sync_on) begin
          st_d = FORWARD_RUN_IN ? spf_pkg::ST_RUN : spf_pkg::ST_ACCUM;
        end
      end
      spf_pkg::ST_ACCUM: begin
        // Pulses are counted but the motor waits for forward run
        if (!sync_on) begin
          st_d = spf_pkg::ST_IDLE;
        end else if (FORWARD_RUN_IN) begin
          st_d = spf_pkg::ST_RUN;
        end
      end
      spf_pkg::ST_RUN: begin
        if (!sync_on) begin
          st_d = spf_pkg::ST_IDLE;
        end else if (!FORWARD_RUN_IN) begin
          st_d = spf_pkg::ST_ACCUM;
        end else if (dev_q == 32'sd0 && rate_q == 16'sd0) begin
          st_d = spf_pkg::ST_LOCK;
        end
      end
      spf_pkg::ST_LOCK: begin
        if (!sync_on) begin
          st_d = spf_pkg::ST_IDLE;
        end else if (!FORWARD_RUN_IN) begin
          st_d = spf_pkg::ST_ACCUM;
        end else if (dev_q != 32'sd0 || rate_q != 16'sd0) begin
          st_d = spf_pkg::ST_RUN;
        end
      end
      default: begin
        st_d = spf_pkg::ST_IDLE;
      end
    endcase
    // Run and lock flags registered from the next state, so pins come from flops
    run_d = (st_d == spf_pkg::ST_RUN) || (st_d == spf_pkg::ST_LOCK);
    lock_d = (st_d == spf_pkg::ST_LOCK);
  end

  ////////////////////////////////////////////////////////////////////
  // Speed command: feed-forward of rate plus proportional deviation
  always_comb begin
    p_term = (48'(signed'(kp_q)) * 48'(dev_q)) >>> 8;
    // Unity ff passes the full rate, so no lag is needed to make speed
    f_term = (48'(signed'(ff_q)) * 48'(rate_q)) >>> 8;
    sum_term = p_term + f_term;
    spd_d = 16'sh0000;
    if (st_q == spf_pkg::ST_RUN || st_q == spf_pkg::ST_LOCK) begin
      // Saturation lets a large backlog run at top speed
      if (sum_term > 48'(MAX_SPEED)) begin
        spd_d = 16'(MAX_SPEED);
      end else if (sum_term < -48'(MAX_SPEED)) begin
        spd_d = -16'(MAX_SPEED);
      end else begin
        spd_d = sum_term[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pulse repeat outputs: open-collector, pulled low while phase low
  always_comb begin
    rpen_d = (outsel_q == `SPF_OUTSEL_REPEAT);
    rpa_d = rpen_d & ~CMD_IN_FIRST_PHASE_IN;
    rpb_d = rpen_d & ~CMD_IN_SECOND_PHASE_IN;
  end
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      st_q <= spf_pkg::ST_IDLE;
      spd_q <= 16'sh0000;
      rpa_q <= 1'b0;
      rpb_q <= 1'b0;
      run_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      st_q <= st_d;
      spd_q <= spd_d;
      rpa_q <= rpa_d;
      rpb_q <= rpb_d;
      run_q <= run_d;
      lock_q <= lock_d;
    end
  end
  assign REPEAT_OUT_FIRST_PHASE_OUT = 1'b0;
  assign REPEAT_OUT_SECOND_PHASE_OUT = 1'b0;
  assign REPEAT_OUT_FIRST_PHASE_OE_OUT = rpa_q;
  assign REPEAT_OUT_SECOND_PHASE_OE_OUT = rpb_q;
  assign SPEED_CMD_OUT = spd_q;
  assign MOTOR_RUN_OUT = run_q;
  assign SERVO_LOCK_OUT = lock_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN && PREADY_OUT;
  endsequence
  a_apb_ready: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    s_setup ##1 PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("access phase not ready at once");
  a_fmt_legal: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    s_access and PWRITE_IN && PADDR_IN == `SPF_CTRL_ADDR
    && PWDATA_IN[5:4] == 2'h3 |=> $stable(fmt_q))
    else $error("illegal format accepted");
  a_ratio_range: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    num_q >= 14'd1 && num_q <= 14'd9999 && den_q >= 14'd1 && den_q <= 14'd9999)
    else $error("ratio out of range");
  a_repeat_copy: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    outsel_q == 4'h9 |=> REPEAT_OUT_FIRST_PHASE_OE_OUT == !$past(CMD_IN_FIRST_PHASE_IN)
    && REPEAT_OUT_SECOND_PHASE_OE_OUT == !$past(CMD_IN_SECOND_PHASE_IN))
    else $error("repeat output differs from input");
  a_repeat_idle: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    outsel_q != 4'h9 |=> !REPEAT_OUT_FIRST_PHASE_OE_OUT && !REPEAT_OUT_SECOND_PHASE_OE_OUT)
    else $error("repeat driven while not selected");
  a_dev_gate: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    !sync_on |=> dev_q == 32'sd0 && !MOTOR_RUN_OUT ##1 1'b1)
    else $error("position loop active without sync");
  a_dev_count: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    sync_on && cmd_up && !FB_STEP_IN |=> dev_q == $past(dev_q) + 32'sd1)
    else $error("command count not added to deviation");
  a_accum_hold: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    st_q == spf_pkg::ST_ACCUM |=> SPEED_CMD_OUT == 16'sd0)
    else $error("motor driven before forward run");
  a_lock_entry: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    st_q == spf_pkg::ST_RUN && sync_on && FORWARD_RUN_IN && dev_q == 32'sd0
    && rate_q == 16'sd0 |=> SERVO_LOCK_OUT)
    else $error("servo lock not entered at zero deviation");
  a_speed_cap: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
    SPEED_CMD_OUT <= 16'(MAX_SPEED) && SPEED_CMD_OUT >= -16'(MAX_SPEED))
    else $error("speed beyond limit");
endmodule

// ### bench/spf_pulse_src.sv
// Command pulse transmitter model driving the follower's pulse input
`timescale 1ns/1ns
module spf_pulse_src (
  input wire logic clk_in,
  output logic a_out,
  output logic b_out
);
  // Both phases rest low between trains
  initial begin
    a_out = 1'h0;
    b_out = 1'h0;
  end
  // Set both phases just after an edge, then hold them two cycles
  task automatic put(input logic a, input logic b);
    a_out <= a;
    b_out <= b;
    repeat (2) @(posedge clk_in);
  endtask
  // Send n pulses or quadrature cycles; the direction is set by fw, not by the invert input
  task automatic send(input logic [1:0] f, input logic fw, input int n);
    logic [7:0] s;
    s = fw ? 8'h78 : 8'hB4;
    for (int i = 0; i < n; i++) begin
      case (f)
        2'h0: begin
          for (int k = 0; k < 4; k++) begin
            put(s[7 - 2 * k], s[6 - 2 * k]);
          end
        end
        2'h1: begin
          put(1'h0, fw);
          put(1'h1, fw);
          put(1'h0, fw);
        end
        default: begin
          put(fw, ~fw);
          put(1'h0, 1'h0);
        end
      endcase
    end
    put(1'h0, 1'h0);
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the synchronized pulse follower
`timescale 1ns/1ns
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("wrong value at %0t ns got %h expected %h", $time, (a), (e)); \
  end \
end
module testbench;
  typedef struct {
    logic [1:0] f;
    logic inv;
    logic fw;
    logic rep;
    int n;
    logic [13:0] num;
    logic [13:0] den;
    int dev;
  } spf_row_t;
  logic clk, nrst, psel, penable, pwrite, inv, forward_run, fb_step, fb_fwd, pa, pb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [13:0] gdi;
  logic pready, pslverr, oe_a, oe_b, rep_a, rep_b, run, lock, rep_en, rep_on, pa_q, pb_q;
  logic signed [15:0] speed;
  int n_fail = 0;
  int comparisons = 0;
  // Formats, directions, ratios and repeat mode, with the deviation each should leave
  spf_row_t rows [10] = '{
    '{2'h0, 1'h0, 1'h1, 1'h1, 2, 14'd1, 14'd1, 8},
    '{2'h0, 1'h0, 1'h0, 1'h0, 1, 14'd1, 14'd1, -4},
    '{2'h0, 1'h1, 1'h1, 1'h0, 1, 14'd1, 14'd1, -4},
    '{2'h0, 1'h1, 1'h0, 1'h1, 1, 14'd1, 14'd1, 4},
    '{2'h1, 1'h0, 1'h1, 1'h1, 8, 14'd1, 14'd1, 2},
    '{2'h1, 1'h1, 1'h0, 1'h0, 8, 14'd1, 14'd1, 2},
    '{2'h2, 1'h0, 1'h1, 1'h0, 4, 14'd1, 14'd1, 1},
    '{2'h2, 1'h1, 1'h0, 1'h1, 8, 14'd1, 14'd1, 2},
    '{2'h0, 1'h0, 1'h1, 1'h0, 1, 14'd3, 14'd2, 6},
    '{2'h1, 1'h0, 1'h1, 1'h0, 4, 14'd9999, 14'd1, 9999}
  };
  ////////////////////////////////////////////////////////////////////////////////
  spf_follower #(.MAX_SPEED(100), .RATE_WIN(16)) i_spf_follower (
    .MCLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CMD_IN_FIRST_PHASE_IN(pa),
    .CMD_IN_SECOND_PHASE_IN(pb), .DIRECTION_INVERT_IN(inv), .FORWARD_RUN_IN(forward_run),
    .GENERAL_DIGITAL_INPUTS_IN(gdi), .FB_STEP_IN(fb_step), .FB_FWD_IN(fb_fwd),
    .REPEAT_OUT_FIRST_PHASE_OUT(rep_a), .REPEAT_OUT_FIRST_PHASE_OE_OUT(oe_a),
    .REPEAT_OUT_SECOND_PHASE_OUT(rep_b), .REPEAT_OUT_SECOND_PHASE_OE_OUT(oe_b),
    .SPEED_CMD_OUT(speed), .MOTOR_RUN_OUT(run), .SERVO_LOCK_OUT(lock)
  );
  spf_pulse_src i_spf_pulse_src (.clk_in(clk), .a_out(pa), .b_out(pb));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Repeated pins pull low while the received phase is low, one cycle late
  always @(posedge clk) begin
    if (rep_on) `CHK({oe_a, oe_b, rep_a, rep_b}, {rep_en & ~pa_q, rep_en & ~pb_q, 2'h0});
    pa_q <= pa;
    pb_q <= pb;
  end
  // One APB transfer: setup, then access held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk iff pready === 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  // Write one register word
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  // Poll the deviation until it reaches the expected count, then compare
  task automatic dev_wait(input logic [31:0] x);
    logic [31:0] q;
    logic e;
    for (int k = 0; k < 5000; k++) begin
      apb(1'h0, 12'h00C, 32'h0000_0000, q, e);
      if (q === x) break;
    end
    `CHK(q, x);
  endtask
  // Print the counts and the verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake or wait
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, register checks, the format table, then run and lock
  initial begin
    logic [31:0] q;
    logic e;
    {nrst, psel, penable, pwrite, inv, forward_run, fb_step, fb_fwd} = 8'h00;
    {rep_en, rep_on} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    gdi = 14'h0000;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    `CHK({lock, run, speed}, 18'h0_0000);
    apb(1'h0, 12'h000, 32'h0000_0000, q, e);
    `CHK(q, 32'h0000_0000);
    apb(1'h0, 12'h004, 32'h0000_0000, q, e);
    `CHK(q, 32'h0001_0001);
    apb(1'h0, 12'h008, 32'h0000_0000, q, e);
    `CHK(q, 32'h0100_0100);
    apb(1'h0, 12'h020, 32'h0000_0000, q, e);
    `CHK({e, q}, 33'h1_0000_0000);
    wr(12'h004, 32'h0000_2710);
    apb(1'h0, 12'h004, 32'h0000_0000, q, e);
    `CHK(q, 32'h0001_270F);
    wr(12'h000, 32'h0000_0030);
    apb(1'h0, 12'h000, 32'h0000_0000, q, e);
    `CHK(q, 32'h0000_0000);
    // Function code other than sync leaves the pulses ignored
    gdi[5] <= 1'h1;
    wr(12'h000, 32'h001A_0500);
    i_spf_pulse_src.send(2'h0, 1'h1, 1);
    apb(1'h0, 12'h00C, 32'h0000_0000, q, e);
    `CHK(q, 32'h0000_0000);
    foreach (rows[i]) begin
      rep_on <= 1'h0;
      wr(12'h004, {2'h0, rows[i].den, 2'h0, rows[i].num});
      wr(12'h000, {11'h000, 5'h1B, 4'h0, 4'h5, 2'h0, rows[i].f, rows[i].rep ? 4'h9 : 4'h0});
      inv <= rows[i].inv;
      rep_en <= rows[i].rep;
      @(posedge clk);
      rep_on <= 1'h1;
      i_spf_pulse_src.send(rows[i].f, rows[i].fw, rows[i].n);
      dev_wait(rows[i].dev);
      gdi[5] <= 1'h0;
      @(posedge clk);
      apb(1'h0, 12'h00C, 32'h0000_0000, q, e);
      `CHK(q, 32'h0000_0000);
      gdi[5] <= 1'h1;
    end
    // Accumulate before the run input, then run, feed back and settle into lock
    rep_on <= 1'h0;
    inv <= 1'h0;
    wr(12'h004, 32'h0001_0001);
    wr(12'h000, 32'h001B_0500);
    i_spf_pulse_src.send(2'h0, 1'h1, 1);
    dev_wait(32'h0000_0004);
    apb(1'h0, 12'h010, 32'h0000_0000, q, e);
    `CHK({q, run}, {32'h0000_0006, 1'h0});
    repeat (40) @(posedge clk);
    wr(12'h008, 32'h0100_0200);
    forward_run <= 1'h1;
    repeat (3) @(posedge clk);
    `CHK({run, speed}, {1'h1, 16'h0008});
    for (int k = 0; k < 6; k++) begin
      fb_fwd <= (k > 0);
      fb_step <= 1'h1;
      @(posedge clk);
      fb_step <= 1'h0;
      @(posedge clk);
    end
    dev_wait(32'h0000_0000);
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      if (lock === 1'h1) break;
    end
    repeat (2) @(posedge clk);
    `CHK({lock, run, speed}, {2'h3, 16'h0000});
    gdi[5] <= 1'h0;
    forward_run <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK({lock, run}, 2'h0);
    close_out();
  end
endmodule
